// ==== test/vbcfg_bridge_header_test.sv ====
// Self-checking testbench of the bridge header bank
`timescale 1ns/10ps
module vbcfg_bridge_header_test;
    logic mclk;
    logic rstn;
    logic cfg_rd;
    logic cfg_wr;
    logic [7:0] cfg_addr;
    logic [3:0] cfg_be;
    logic [31:0] cfg_wdata;
    logic [7:0] main_revision_value;
    logic system_error_enable;
    logic serr_condition;
    logic [31:0] cfg_rdata_ff;
    logic cfg_ack_ff;
    logic hub_link_serr_msg_ff;
    logic [7:0] bus_number_field_ff;
    logic system_error_sent_flag;
    int fails = 0;
    int checked = 0;
    int cycles = 0;
    logic [4:0] m_lat = 5'h00;
    logic [7:0] m_bus = 8'h00;
    logic m_flag = 1'b0;
    logic [7:0] a;

    vbcfg_bridge_header dut (
        .mclk(mclk), .rstn(rstn), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
        .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
        .main_revision_value(main_revision_value),
        .system_error_enable(system_error_enable),
        .serr_condition(serr_condition), .cfg_rdata_ff(cfg_rdata_ff),
        .cfg_ack_ff(cfg_ack_ff), .hub_link_serr_msg_ff(hub_link_serr_msg_ff),
        .bus_number_field_ff(bus_number_field_ff),
        .system_error_sent_flag(system_error_sent_flag)
    );

    initial mclk = 1'b0;
    always #10 mclk = ~mclk;

    task report_and_stop;
        if (fails == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            report_and_stop;
        end
    end

    task cmp32(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("unexpected t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task cmp8(input logic [7:0] got, input logic [7:0] exp);
        cmp32({24'h00_0000, got}, {24'h00_0000, exp});
    endtask

    task cmp1(input logic got, input logic exp);
        cmp32({31'h0000_0000, got}, {31'h0000_0000, exp});
    endtask

    // Expected dword contents from the bench's own model
    function automatic logic [31:0] exp_read(input logic [7:0] ad);
        case (ad[7:2])
            6'h01: exp_read = {1'b0, m_flag, 14'h00a0, 16'h0000};
            6'h02: exp_read = {16'h0604, 8'h00, main_revision_value};
            6'h03: exp_read = {16'h0001, m_lat, 11'h000};
            6'h06: exp_read = {16'h0000, m_bus, 8'h00};
            default: exp_read = 32'h0000_0000;
        endcase
    endfunction

    task access(input logic wr, input logic [7:0] ad, input logic [3:0] be,
                input logic [31:0] d);
        @(negedge mclk);
        cmp1(cfg_ack_ff, 1'b0);
        cfg_wr = wr;
        cfg_rd = !wr;
        cfg_addr = ad;
        cfg_be = be;
        cfg_wdata = d;
        @(negedge mclk);
        cfg_wr = 1'b0;
        cfg_rd = 1'b0;
        cfg_addr = ~ad;
        cfg_wdata = ~d;
        cmp1(cfg_ack_ff, 1'b1);
    endtask

    task rd_chk(input logic [7:0] ad);
        logic [31:0] e;
        e = exp_read(ad);
        access(1'b0, ad, 4'h0, 32'h0000_0000);
        cmp32(cfg_rdata_ff, e);
    endtask

    task wr_upd(input logic [7:0] ad, input logic [3:0] be,
                input logic [31:0] d);
        access(1'b1, ad, be, d);
        if (ad[7:2] == 6'h03 && be[1]) m_lat = d[15:11];
        if (ad[7:2] == 6'h06 && be[1]) m_bus = d[15:8];
        if (ad[7:2] == 6'h01 && be[3] && d[30]) m_flag = 1'b0;
        cmp8(bus_number_field_ff, m_bus);
    endtask

    task serr_pulse(input logic en);
        @(negedge mclk);
        serr_condition = 1'b1;
        system_error_enable = en;
        @(negedge mclk);
        serr_condition = 1'b0;
        cmp1(hub_link_serr_msg_ff, en);
        @(negedge mclk);
        cmp1(hub_link_serr_msg_ff, 1'b0);
        m_flag = m_flag | en;
        cmp1(system_error_sent_flag, m_flag);
    endtask

    // Clear write in the cycle of a message; the set must win
    task serr_clear_collide;
        @(negedge mclk);
        serr_condition = 1'b1;
        system_error_enable = 1'b1;
        access(1'b1, 8'h04, 4'h8, 32'h4000_0000);
        cmp1(system_error_sent_flag, 1'b1);
        serr_condition = 1'b0;
        m_flag = 1'b1;
    endtask

    initial begin
        rstn = 1'b0;
        cfg_rd = 1'b0;
        cfg_wr = 1'b0;
        cfg_addr = 8'h00;
        cfg_be = 4'h0;
        cfg_wdata = 32'h0000_0000;
        system_error_enable = 1'b0;
        serr_condition = 1'b0;
        void'($urandom(32'h240b));
        main_revision_value = 8'($urandom);
        repeat (20) @(negedge mclk);
        rstn = 1'b1;
        cmp8(bus_number_field_ff, 8'h00);
        for (int i = 0; i < 8; i++) begin
            a = (i < 4) ? 8'h04 + 8'(i * 4) : 8'h10 + 8'(i * 12);
            if (i == 3) a = 8'h18;
            rd_chk(a);
        end
        wr_upd(8'h04, 4'hf, 32'hbfff_ffff);
        rd_chk(8'h06);
        wr_upd(8'h08, 4'hf, 32'hffff_ffff);
        rd_chk(8'h0b);
        wr_upd(8'h0c, 4'hf, 32'hffff_ffff);
        rd_chk(8'h0d);
        wr_upd(8'h18, 4'hf, 32'hffff_ffff);
        rd_chk(8'h19);
        serr_pulse(1'b0);
        rd_chk(8'h04);
        serr_pulse(1'b1);
        rd_chk(8'h04);
        wr_upd(8'h04, 4'hf, 32'hbfff_ffff);
        wr_upd(8'h04, 4'h7, 32'hffff_ffff);
        rd_chk(8'h04);
        wr_upd(8'h04, 4'h8, 32'h4000_0000);
        rd_chk(8'h04);
        serr_clear_collide;
        rd_chk(8'h04);
        for (int n = 0; n < 300; n++) begin
            main_revision_value = 8'($urandom);
            case ($urandom % 5)
                0: a = 8'h04;
                1: a = 8'h08;
                2: a = 8'h0c;
                3: a = 8'h18;
                default: a = 8'($urandom);
            endcase
            a[1:0] = 2'($urandom);
            if ($urandom % 2) wr_upd(a, 4'($urandom), $urandom);
            else rd_chk(a);
            if ($urandom % 8 == 0) serr_pulse(1'($urandom));
        end
        report_and_stop;
    end
endmodule

// ==== verilog/vbcfg_bridge_header.sv ====
// Configuration header bank of the virtual bridge function
//
// Operation
// R01 - Sent system-error message sets status 14, W1C
// R02 - Status bit 15 parity flag reads zero
// R03 - Status bits 13:11 abort flags read zero
// R04 - Select timing bits 10:9 read 00b
// R05 - Status bit 8 reads zero, ignores clears
// R06 - Status bit 7 reads constant one
// R07 - Status bit 5 reads constant one
// R08 - Revision mirrors the main revision value
// R09 - Sub-class reads constant 04h
// R10 - Base class reads constant 06h
// R11 - Latency bits 7:3 are plain scratchpad
// R12 - Header type reads constant 01h
// R13 - Upstream bus number hardwired to 00h
// R14 - Downstream bus number is read/write byte
// R15 - No system-error message while enable is low
// R16 - Reserved bits read zero, ignore writes
`timescale 1ns/10ps
`include "vbcfg_map.svh"
module vbcfg_bridge_header (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic cfg_rd,
    input wire logic cfg_wr,
    input wire logic [7:0] cfg_addr,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    input wire logic [7:0] main_revision_value,
    input wire logic system_error_enable,
    input wire logic serr_condition,
    output logic [31:0] cfg_rdata_ff,
    output logic cfg_ack_ff,
    output logic hub_link_serr_msg_ff,
    output logic [7:0] bus_number_field_ff,
    output logic system_error_sent_flag
);
    // Dword indices of the mapped registers
    localparam vbcfg_pkg::vbcfg_index_type IDX_STATUS =
        vbcfg_pkg::vbcfg_index_type'(`VBCFG_OFF_PRIMARY_STATUS >> 2);
    localparam vbcfg_pkg::vbcfg_index_type IDX_CLASS =
        vbcfg_pkg::vbcfg_index_type'(`VBCFG_OFF_REVISION >> 2);
    localparam vbcfg_pkg::vbcfg_index_type IDX_MISC =
        vbcfg_pkg::vbcfg_index_type'(`VBCFG_OFF_LATENCY >> 2);
    localparam vbcfg_pkg::vbcfg_index_type IDX_BUS =
        vbcfg_pkg::vbcfg_index_type'(`VBCFG_OFF_UPSTREAM_BUS >> 2);

    // Byte lanes of the writable registers inside their dwords
    localparam int LANE_STATUS_HI = (`VBCFG_OFF_PRIMARY_STATUS & 3) + 1;
    localparam int LANE_LATENCY = `VBCFG_OFF_LATENCY & 3;
    localparam int LANE_DOWNSTREAM = `VBCFG_OFF_DOWNSTREAM_BUS & 3;
    localparam int SYS_ERR_WBIT = 16 + `VBCFG_ST_SYS_ERR_BIT;

    vbcfg_pkg::vbcfg_index_type acc_index;
    vbcfg_pkg::vbcfg_acc_type acc_kind;
    logic hit_status;
    logic hit_class;
    logic hit_misc;
    logic hit_bus;
    logic status_hi_lane;
    logic latency_lane;
    logic downstream_lane;
    logic sys_err_clear;
    logic latency_write;
    logic downstream_write;
    logic [15:0] status_view;
    vbcfg_pkg::vbcfg_dword_type status_dword;
    vbcfg_pkg::vbcfg_dword_type class_dword;
    vbcfg_pkg::vbcfg_dword_type misc_dword;
    vbcfg_pkg::vbcfg_dword_type bus_dword;
    vbcfg_pkg::vbcfg_dword_type nxt_rdata;
    logic [4:0] latency_scratch_bits_ff;
    logic [4:0] nxt_latency;
    logic [7:0] nxt_downstream;
    logic nxt_serr_msg;

    // Access decode; a write takes precedence over a read
    assign acc_kind = cfg_wr ? vbcfg_pkg::VBCFG_ACC_WRITE :
                      cfg_rd ? vbcfg_pkg::VBCFG_ACC_READ :
                      vbcfg_pkg::VBCFG_ACC_NONE;
    assign acc_index = cfg_addr[7:2];
    assign hit_status = (acc_index == IDX_STATUS);
    assign hit_class = (acc_index == IDX_CLASS);
    assign hit_misc = (acc_index == IDX_MISC);
    assign hit_bus = (acc_index == IDX_BUS);
    assign status_hi_lane = cfg_be[LANE_STATUS_HI];
    assign latency_lane = cfg_be[LANE_LATENCY];
    assign downstream_lane = cfg_be[LANE_DOWNSTREAM];

    // Write strobes; all other status bits ignore writes
    assign sys_err_clear = (acc_kind == vbcfg_pkg::VBCFG_ACC_WRITE) &&
        hit_status && status_hi_lane && cfg_wdata[SYS_ERR_WBIT]; // R01
    assign latency_write = (acc_kind == vbcfg_pkg::VBCFG_ACC_WRITE) &&
        hit_misc && latency_lane; // R11
    assign downstream_write = (acc_kind == vbcfg_pkg::VBCFG_ACC_WRITE) &&
        hit_bus && downstream_lane; // R14

    // Message to the hub link only while the enable is set
    assign nxt_serr_msg = serr_condition & system_error_enable; // R15

    // Next values of the writable fields
    assign nxt_latency = latency_write ?
        cfg_wdata[LANE_LATENCY*8+`VBCFG_LAT_MSB:LANE_LATENCY*8+`VBCFG_LAT_LSB]
        : latency_scratch_bits_ff; // R11
    assign nxt_downstream = downstream_write ?
        cfg_wdata[LANE_DOWNSTREAM*8+7:LANE_DOWNSTREAM*8]
        : bus_number_field_ff; // R14

    // Status word as seen by software
    always_comb begin
        status_view = 16'h0000; // R16
        status_view[`VBCFG_ST_PARITY_ERR_BIT] = 1'b0; // R02
        status_view[`VBCFG_ST_SYS_ERR_BIT] = system_error_sent_flag; // R01
        status_view[13:11] = 3'h0; // R03
        status_view[10:9] = `VBCFG_ST_SELECT_TIMING; // R04
        status_view[8] = 1'b0; // R05
        status_view[`VBCFG_ST_BACK_TO_BACK_BIT] = 1'b1; // R06
        status_view[`VBCFG_ST_HIGH_SPEED_BIT] = 1'b1; // R07
    end

    // Dword images of each mapped location
    assign status_dword = {status_view, 16'h0000};
    assign class_dword = {`VBCFG_BASE_CLASS_VAL, // R10
                          `VBCFG_SUB_CLASS_VAL, // R09
                          `VBCFG_PROG_IF_VAL,
                          main_revision_value}; // R08
    assign misc_dword = {8'h00,
                         `VBCFG_HEADER_TYPE_VAL, // R12
                         latency_scratch_bits_ff, 3'h0, // R11 R16
                         8'h00};
    assign bus_dword = {16'h0000,
                        bus_number_field_ff, // R14
                        `VBCFG_UPSTREAM_BUS_VAL}; // R13

    // Read data mux; unmapped dwords read as zero
    assign nxt_rdata = hit_status ? status_dword :
                       hit_class ? class_dword :
                       hit_misc ? misc_dword :
                       hit_bus ? bus_dword :
                       32'h0000_0000;

    // Sticky system-error flag
    vbcfg_sticky_flag u_sys_err_flag (
        .mclk(mclk),
        .rstn(rstn),
        .set_pulse(hub_link_serr_msg_ff), // R01
        .clr_pulse(sys_err_clear),
        .flag_ff(system_error_sent_flag)
    );

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            hub_link_serr_msg_ff <= 1'b0;
        end else begin
            hub_link_serr_msg_ff <= nxt_serr_msg; // R15
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            latency_scratch_bits_ff <= `VBCFG_LATENCY_RESET;
            bus_number_field_ff <= `VBCFG_DOWNSTREAM_RESET;
        end else begin
            latency_scratch_bits_ff <= nxt_latency;
            bus_number_field_ff <= nxt_downstream;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cfg_ack_ff <= 1'b0;
        end else begin
            cfg_ack_ff <= (acc_kind != vbcfg_pkg::VBCFG_ACC_NONE);
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cfg_rdata_ff <= 32'h0000_0000;
        end else if (acc_kind == vbcfg_pkg::VBCFG_ACC_READ) begin
            cfg_rdata_ff <= nxt_rdata;
        end
    end

    // Checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    logic rd_status;
    logic rd_class;
    logic rd_misc;
    logic rd_bus;
    assign rd_status = (acc_kind == vbcfg_pkg::VBCFG_ACC_READ) && hit_status;
    assign rd_class = (acc_kind == vbcfg_pkg::VBCFG_ACC_READ) && hit_class;
    assign rd_misc = (acc_kind == vbcfg_pkg::VBCFG_ACC_READ) && hit_misc;
    assign rd_bus = (acc_kind == vbcfg_pkg::VBCFG_ACC_READ) && hit_bus;
    logic rd_none;
    logic wr_status;
    assign rd_none = (acc_kind == vbcfg_pkg::VBCFG_ACC_READ) &&
        !(hit_status || hit_class || hit_misc || hit_bus);
    assign wr_status = (acc_kind == vbcfg_pkg::VBCFG_ACC_WRITE) &&
        hit_status;

    sequence s_serr_sent;
        serr_condition && system_error_enable ##1 hub_link_serr_msg_ff;
    endsequence

    sequence s_lat_write_then_read;
        latency_write ##1 rd_misc && !latency_write;
    endsequence

    sequence s_status_write_then_read;
        wr_status ##2 rd_status;
    endsequence

    sequence s_flag_clear_then_read;
        sys_err_clear && !hub_link_serr_msg_ff ##1 !hub_link_serr_msg_ff
            ##1 rd_status;
    endsequence

    a_serr_sets_flag: assert property ( // R01
        s_serr_sent |=> system_error_sent_flag)
        else $error("system error message did not set flag");

    a_flag_w1_clears: assert property ( // R01
        sys_err_clear && !hub_link_serr_msg_ff |=> !system_error_sent_flag)
        else $error("write of one did not clear flag");

    a_flag_w0_holds: assert property ( // R01
        system_error_sent_flag && !sys_err_clear |=> system_error_sent_flag)
        else $error("flag dropped without a clear");

    a_parity_reads_zero: assert property ( // R02
        rd_status |=> !cfg_rdata_ff[31])
        else $error("parity error flag read as one");

    a_aborts_read_zero: assert property ( // R03
        rd_status |=> cfg_rdata_ff[29:27] == 3'h0)
        else $error("abort flags read non-zero");

    a_select_timing_zero: assert property ( // R04
        rd_status |=> cfg_rdata_ff[26:25] == 2'h0)
        else $error("select timing not 00b");

    a_data_parity_zero: assert property ( // R05
        rd_status |=> !cfg_rdata_ff[24])
        else $error("data parity flag read as one");

    a_fast_b2b_one: assert property ( // R06
        rd_status |=> cfg_rdata_ff[23])
        else $error("back to back bit not one");

    a_high_speed_one: assert property ( // R07
        rd_status |=> cfg_rdata_ff[21])
        else $error("high speed bit not one");

    a_revision_mirror: assert property ( // R08
        rd_class |=> cfg_rdata_ff[7:0] == $past(main_revision_value))
        else $error("revision differs from main revision");

    a_class_codes: assert property ( // R09 R10
        rd_class |=> cfg_rdata_ff[31:16] == 16'h0604)
        else $error("class codes wrong");

    a_latency_scratch: assert property ( // R11
        s_lat_write_then_read |=>
            cfg_rdata_ff[15:11] == $past(cfg_wdata[15:11], 2))
        else $error("latency scratch lost written value");

    a_header_type: assert property ( // R12
        rd_misc |=> cfg_rdata_ff[23:16] == 8'h01)
        else $error("header type not 01h");

    a_upstream_bus: assert property ( // R13
        rd_bus |=> cfg_rdata_ff[7:0] == 8'h00)
        else $error("upstream bus number not zero");

    a_downstream_write: assert property ( // R14
        downstream_write |=> bus_number_field_ff == $past(cfg_wdata[15:8]))
        else $error("downstream bus number not written");

    a_serr_gated: assert property ( // R15
        !system_error_enable |=> !hub_link_serr_msg_ff ##1
            ($stable(system_error_sent_flag) || !system_error_sent_flag))
        else $error("message sent while disabled");

    a_reserved_zero: assert property ( // R16
        rd_status |=> cfg_rdata_ff[22] == 1'b0 &&
            cfg_rdata_ff[20:16] == 5'h00 && cfg_rdata_ff[15:0] == 16'h0000)
        else $error("reserved status bits non-zero");

    a_lat_reserved: assert property ( // R16
        rd_misc |=> cfg_rdata_ff[10:8] == 3'h0)
        else $error("reserved latency bits non-zero");

    a_access_ack: assert property (
        (cfg_rd || cfg_wr) |=> cfg_ack_ff ##1
            (cfg_ack_ff == $past(cfg_rd || cfg_wr)))
        else $error("access not acknowledged");

    a_ack_idle: assert property (
        !cfg_rd && !cfg_wr |=> !cfg_ack_ff)
        else $error("acknowledge without an access");

    a_flag_read: assert property ( // R01
        rd_status |=> cfg_rdata_ff[30] == $past(system_error_sent_flag))
        else $error("status bit 14 differs from flag");

    a_set_wins_clear: assert property ( // R01
        hub_link_serr_msg_ff && sys_err_clear |=> system_error_sent_flag)
        else $error("clear beat a simultaneous set");

    a_flag_no_spurious: assert property ( // R01 R15
        !system_error_sent_flag && !hub_link_serr_msg_ff |=>
            !system_error_sent_flag)
        else $error("flag set without a message");

    a_flag_clear_read: assert property ( // R01
        s_flag_clear_then_read |=> !cfg_rdata_ff[30])
        else $error("cleared flag still read as one");

    a_msg_follows: assert property ( // R15
        serr_condition && system_error_enable |=> hub_link_serr_msg_ff)
        else $error("enabled error sent no message");

    a_msg_quiet: assert property ( // R15
        !serr_condition |=> !hub_link_serr_msg_ff)
        else $error("message without an error condition");

    a_ro_status_write: assert property ( // R02 R03 R05
        s_status_write_then_read |=>
            !cfg_rdata_ff[31] && cfg_rdata_ff[29:24] == 6'h00)
        else $error("read-only status bits took a write");

    a_latency_hold: assert property ( // R11
        !latency_write |=> $stable(latency_scratch_bits_ff))
        else $error("latency scratch changed without a write");

    a_latency_read: assert property ( // R11
        rd_misc |=> cfg_rdata_ff[15:11] == $past(latency_scratch_bits_ff))
        else $error("latency scratch read wrong");

    a_downstream_hold: assert property ( // R14
        !downstream_write |=> $stable(bus_number_field_ff))
        else $error("downstream bus changed without a write");

    a_downstream_read: assert property ( // R14
        rd_bus |=> cfg_rdata_ff[15:8] == $past(bus_number_field_ff))
        else $error("downstream bus read wrong");

    a_unmapped_zero: assert property (
        rd_none |=> cfg_rdata_ff == 32'h0000_0000)
        else $error("unmapped location read non-zero");

    a_rdata_holds: assert property (
        acc_kind != vbcfg_pkg::VBCFG_ACC_READ |=> $stable(cfg_rdata_ff))
        else $error("read data changed without a read");
endmodule

// ==== verilog/vbcfg_map.svh ====
// Offsets, field positions and fixed values of the bridge header bank
`ifndef VBCFG_MAP_SVH
`define VBCFG_MAP_SVH

// Byte offsets within configuration space
`define VBCFG_OFF_PRIMARY_STATUS 8'h06
`define VBCFG_OFF_REVISION 8'h08
`define VBCFG_OFF_SUB_CLASS 8'h0a
`define VBCFG_OFF_BASE_CLASS 8'h0b
`define VBCFG_OFF_LATENCY 8'h0d
`define VBCFG_OFF_HEADER_TYPE 8'h0e
`define VBCFG_OFF_UPSTREAM_BUS 8'h18
`define VBCFG_OFF_DOWNSTREAM_BUS 8'h19

// Status register fields
`define VBCFG_ST_PARITY_ERR_BIT 15
`define VBCFG_ST_SYS_ERR_BIT 14
`define VBCFG_ST_BACK_TO_BACK_BIT 7
`define VBCFG_ST_HIGH_SPEED_BIT 5
`define VBCFG_ST_SELECT_TIMING 2'h0

// Latency scratch field
`define VBCFG_LAT_MSB 7
`define VBCFG_LAT_LSB 3

// Fixed register values and reset values
`define VBCFG_STATUS_RESET 16'h00a0
`define VBCFG_SUB_CLASS_VAL 8'h04
`define VBCFG_BASE_CLASS_VAL 8'h06
`define VBCFG_HEADER_TYPE_VAL 8'h01
`define VBCFG_UPSTREAM_BUS_VAL 8'h00
`define VBCFG_LATENCY_RESET 5'h00
`define VBCFG_DOWNSTREAM_RESET 8'h00
`define VBCFG_PROG_IF_VAL 8'h00

`endif

// ==== verilog/vbcfg_pkg.sv ====
// Types shared by the bridge header bank
package vbcfg_pkg;

    typedef logic [7:0] vbcfg_byte_type;
    typedef logic [31:0] vbcfg_dword_type;
    typedef logic [5:0] vbcfg_index_type;

    typedef enum logic [1:0] {
        VBCFG_ACC_NONE,
        VBCFG_ACC_READ,
        VBCFG_ACC_WRITE
    } vbcfg_acc_type;

endpackage

// ==== verilog/vbcfg_sticky_flag.sv ====
// Sticky event flag with write-one-to-clear, set beats clear
`timescale 1ns/10ps
module vbcfg_sticky_flag (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic set_pulse,
    input wire logic clr_pulse,
    output logic flag_ff
);
    logic nxt_flag;

    // Set wins over a clear in the same cycle
    assign nxt_flag = set_pulse | (flag_ff & ~clr_pulse);

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            flag_ff <= 1'b0;
        end else begin
            flag_ff <= nxt_flag;
        end
    end

    a_set_beats_clear: assert property (@(posedge mclk) disable iff (!rstn)
        set_pulse |=> flag_ff) // R01
        else $error("flag lost a set event");
endmodule
